// ===== src/alarm_pkg.sv
// Package of shared constants and types for the line alarm signal handler.
// Assumes a single 250 MHz clock domain and an Avalon-MM register slave.
package alarm_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_LINES = 4;
    localparam int SLOTS     = 32;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_GEN_EN   = 8'h04;
    localparam logic [7:0] OFS_FWD_EN   = 8'h08;
    localparam logic [7:0] OFS_SLOT_MAP = 8'h0c;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_LIVE     = 8'h18;

    // ----------------------------------------------------------------
    // Control field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [NUM_LINES-1:0] EN_RESET = 4'h0;
    localparam logic [SLOTS-1:0] SLOT_RESET = 32'hffffffff;

    // ----------------------------------------------------------------
    // Service channel pacing
    // ----------------------------------------------------------------
    localparam int SVC_PERIOD_US = 1000;
    localparam int CLK_MHZ       = 250;
    localparam int SVC_CYCLES    = SVC_PERIOD_US * CLK_MHZ;

    // Operating modes
    typedef enum logic [1:0] {
        fractional_e1_mode = 2'b00,
        fractional_t1_mode = 2'b01,
        full_rate_mode     = 2'b10
    } mode_t;

    // Outgoing line content selection
    typedef enum logic [1:0] {
        OUT_RECON   = 2'b00,
        OUT_AIS     = 2'b01,
        OUT_SLOTS1  = 2'b10,
        OUT_ZEROS   = 2'b11
    } out_sel_t;

endpackage

// ===== src/alarm_sync.sv
// Two flip-flop synchroniser for a bus of asynchronous levels.
// Assumes inputs come from pins outside the sys_clk domain.
`timescale 1ns/1ns
module alarm_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// ===== src/line_alarm_signal_handler.sv
// Alarm generation and forwarding for four E1/T1 lines of a radio link.
// Assumes one clock; line status pins are asynchronous; far-end flags arrive
// over a slow service channel as levels on the same clock.
`timescale 1ns/1ns
module line_alarm_signal_handler #(
    parameter int SVC_PERIOD = alarm_pkg::SVC_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Local line receiver status pins
    input  wire logic [3:0]  line_los,
    input  wire logic [3:0]  line_ais_in,
    input  wire logic [3:0]  line_rai_in,
    input  wire logic [3:0]  line_mf_loss,
    // Modem status pin
    input  wire logic        demod_lock,
    // Far-end flags from the service channel
    input  wire logic [3:0]  far_ais,
    input  wire logic [3:0]  far_rai,
    input  wire logic [3:0]  far_fault,
    // Flags toward the service channel
    output logic      [3:0]  svc_ais,
    output logic      [3:0]  svc_rai,
    output logic      [3:0]  svc_fault,
    // Per-line transmitter control
    output logic      [7:0]  line_out_sel,
    output logic      [3:0]  line_tx_rai,
    output logic      [3:0]  multiframe_remote_alarm,
    output logic      [31:0] slot_fill_mask,
    output logic             irq
);

    // ----------------------------------------------------------------
    // Synchronised inputs and state
    // ----------------------------------------------------------------
    logic [3:0]  los_s;
    logic [3:0]  ais_s;
    logic [3:0]  rai_s;
    logic [3:0]  mf_s;
    logic        lock_s;
    logic        tick;
    logic [1:0]  mode;
    logic [3:0]  gen_en;
    logic [3:0]  fwd_en;
    logic [31:0] slot_map;
    logic [7:0]  status;
    logic [7:0]  irq_mask;
    logic [3:0]  far_ais_l;
    logic [3:0]  far_rai_l;
    logic [3:0]  far_fault_l;
    logic        lock_d;
    logic [3:0]  ais_d;
    logic [7:0]  next_sel;
    logic [3:0]  next_rai;
    logic [3:0]  next_mf;
    logic        wr_hit;
    logic        rd_status;
    logic [7:0]  events;
    logic        full_rate;
    logic        frac_e1;
    logic        rd_done;

    alarm_sync #(.W(17)) u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({line_los, line_ais_in, line_rai_in, line_mf_loss, demod_lock}),
        .sync_out ({los_s, ais_s, rai_s, mf_s, lock_s})
    );

    svc_tick #(.PERIOD(SVC_PERIOD)) u_tick (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .tick    (tick)
    );

    assign full_rate = (mode == alarm_pkg::full_rate_mode);
    assign frac_e1   = (mode == alarm_pkg::fractional_e1_mode);

    // Register decode helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ----------------------------------------------------------------
    // Avalon-MM slave
    // ----------------------------------------------------------------
    // Reads take one wait state so registered data stands when waitrequest is low
    // Writes take none; status clears once, on the loading edge
    assign avs_waitrequest = avs_read && !rd_done;
    assign wr_hit          = avs_write;
    assign rd_status       = avs_read && !rd_done && hit(avs_address, alarm_pkg::OFS_STATUS);

    // Marks the cycle in which read data has been loaded
    always_ff @(posedge sys_clk) begin
        if (!reset_n)
            rd_done <= 1'b0;
        else
            rd_done <= avs_read && !rd_done;
    end

    // Configuration registers
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mode     <= alarm_pkg::MODE_RESET;
            gen_en   <= alarm_pkg::EN_RESET;
            fwd_en   <= alarm_pkg::EN_RESET;
            slot_map <= alarm_pkg::SLOT_RESET;
            irq_mask <= 8'h00;
        end else if (wr_hit) begin
            if (hit(avs_address, alarm_pkg::OFS_CONTROL))
                mode <= avs_writedata[alarm_pkg::CTRL_MODE_LSB +: 2];
            if (hit(avs_address, alarm_pkg::OFS_GEN_EN))
                gen_en <= avs_writedata[3:0];
            if (hit(avs_address, alarm_pkg::OFS_FWD_EN))
                fwd_en <= avs_writedata[3:0];
            if (hit(avs_address, alarm_pkg::OFS_SLOT_MAP))
                slot_map <= avs_writedata;
            if (hit(avs_address, alarm_pkg::OFS_IRQ_MASK))
                irq_mask <= avs_writedata[7:0];
        end
    end

    // Read data mux, registered
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !rd_done) begin
            unique case (avs_address)
                alarm_pkg::OFS_CONTROL:  avs_readdata <= {30'h0, mode};
                alarm_pkg::OFS_GEN_EN:   avs_readdata <= {28'h0, gen_en};
                alarm_pkg::OFS_FWD_EN:   avs_readdata <= {28'h0, fwd_en};
                alarm_pkg::OFS_SLOT_MAP: avs_readdata <= slot_map;
                alarm_pkg::OFS_STATUS:   avs_readdata <= {24'h0, status};
                alarm_pkg::OFS_IRQ_MASK: avs_readdata <= {24'h0, irq_mask};
                alarm_pkg::OFS_LIVE:     avs_readdata <= {23'h0, lock_s, far_fault_l, los_s};
                default:                 avs_readdata <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Service channel exchange
    // ----------------------------------------------------------------
    // Flags move only on the slow tick in both directions
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            svc_ais     <= 4'h0;
            svc_rai     <= 4'h0;
            svc_fault   <= 4'h0;
            far_ais_l   <= 4'h0;
            far_rai_l   <= 4'h0;
            far_fault_l <= 4'h0;
        end else if (tick) begin
            svc_ais     <= ais_s & fwd_en;
            svc_rai     <= rai_s & fwd_en;
            svc_fault   <= los_s;
            far_ais_l   <= far_ais;
            far_rai_l   <= far_rai;
            far_fault_l <= far_fault;
        end
    end

    // ----------------------------------------------------------------
    // Transmit content decision
    // ----------------------------------------------------------------
    always_comb begin
        next_sel = 8'h00;
        next_rai = 4'h0;
        next_mf  = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (full_rate) begin
                if (!lock_s)
                    next_sel[2*i +: 2] = alarm_pkg::OUT_AIS;
                else if (fwd_en[i] && far_ais_l[i])
                    next_sel[2*i +: 2] = alarm_pkg::OUT_AIS;
                else if (far_fault_l[i])
                    next_sel[2*i +: 2] = gen_en[i] ? alarm_pkg::OUT_AIS
                                                   : alarm_pkg::OUT_ZEROS;
                else
                    next_sel[2*i +: 2] = alarm_pkg::OUT_RECON;
                next_rai[i] = fwd_en[i] && far_rai_l[i];
            end else begin
                if (!lock_s || far_fault_l[i])
                    next_sel[2*i +: 2] = gen_en[i] ? alarm_pkg::OUT_AIS
                                                   : alarm_pkg::OUT_SLOTS1;
                else if (far_ais_l[i])
                    next_sel[2*i +: 2] = fwd_en[i] ? alarm_pkg::OUT_AIS
                                                   : alarm_pkg::OUT_SLOTS1;
                else
                    next_sel[2*i +: 2] = alarm_pkg::OUT_RECON;
                next_rai[i] = (gen_en[i] && (los_s[i] || ais_s[i]))
                            || (fwd_en[i] && far_rai_l[i]);
                next_mf[i]  = frac_e1 && gen_en[i] && mf_s[i];
            end
        end
    end

    // Registered line transmitter controls
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            line_out_sel            <= 8'h00;
            line_tx_rai             <= 4'h0;
            multiframe_remote_alarm <= 4'h0;
            slot_fill_mask          <= 32'h0;
        end else begin
            line_out_sel            <= next_sel;
            line_tx_rai             <= next_rai;
            multiframe_remote_alarm <= next_mf;
            slot_fill_mask          <= full_rate ? 32'h0 : slot_map;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lock_d <= 1'b0;
            ais_d  <= 4'h0;
        end else begin
            lock_d <= lock_s;
            ais_d  <= ais_s;
        end
    end

    // Bits 3:0 line AIS rising, bit 4 lock lost
    assign events = {3'h0, lock_d & ~lock_s, ais_s & ~ais_d};

    // Sticky bits, read clears, a new event wins
    always_ff @(posedge sys_clk) begin
        if (!reset_n)
            status <= 8'h00;
        else
            status <= (rd_status ? 8'h00 : status) | events;
    end

    assign irq = |(status & irq_mask);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_enable_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
        avs_write && hit(avs_address, alarm_pkg::OFS_GEN_EN) |=> gen_en == $past(avs_writedata[3:0]))
        else $error("generation enable not written");
    a_enable_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
        avs_read && !rd_done && hit(avs_address, alarm_pkg::OFS_FWD_EN)
        |=> avs_readdata == {28'h0, $past(fwd_en)})
        else $error("forwarding enable readback wrong");
    a_read_ready: assert property (@(posedge sys_clk) disable iff (!reset_n)
        avs_read && !rd_done |=> !avs_waitrequest)
        else $error("read data not offered after one wait state");
    a_unlock_ais: assert property (@(posedge sys_clk) disable iff (!reset_n)
        full_rate && !lock_s |=> line_out_sel[1:0] == alarm_pkg::OUT_AIS)
        else $error("full rate unlock without AIS");
    a_fullrate_zeros: assert property (@(posedge sys_clk) disable iff (!reset_n)
        full_rate && lock_s && far_fault_l[0] && !gen_en[0] && !(fwd_en[0] && far_ais_l[0])
        |=> line_out_sel[1:0] == alarm_pkg::OUT_ZEROS)
        else $error("full rate lost input not zeros");
    a_fullrate_no_rai: assert property (@(posedge sys_clk) disable iff (!reset_n)
        full_rate && !(fwd_en[0] && far_rai_l[0]) |=> !line_tx_rai[0] && !multiframe_remote_alarm[0])
        else $error("full rate originated RAI");
    a_gen_ais: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !full_rate && !lock_s && gen_en[0] |=> line_out_sel[1:0] == alarm_pkg::OUT_AIS)
        else $error("generation did not force AIS");
    a_nogen_slots: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !full_rate && !lock_s && !gen_en[1] |=> line_out_sel[3:2] == alarm_pkg::OUT_SLOTS1)
        else $error("fault without generation not framed");
    a_back_rai: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !full_rate && gen_en[2] && los_s[2] |=> line_tx_rai[2])
        else $error("no RAI toward faulty source");
    a_mf_alarm: assert property (@(posedge sys_clk) disable iff (!reset_n)
        frac_e1 && gen_en[2] && mf_s[2] |=> multiframe_remote_alarm[2])
        else $error("multiframe loss without alarm");
    a_svc_paced: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !tick |=> $stable(svc_ais) && $stable(svc_rai))
        else $error("service flags moved off tick");

    // ----------------------------------------------------------------
    // Forwarding and generation checks
    // ----------------------------------------------------------------
    // Line decisions show one edge after their causes
    a_fwd_ais: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !full_rate && lock_s && !far_fault_l[0] && fwd_en[0] && far_ais_l[0] |=> line_out_sel[1:0] == alarm_pkg::OUT_AIS)
        else $error("far AIS not forwarded");
    a_fwd_rai: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !full_rate && fwd_en[1] && far_rai_l[1] |=> line_tx_rai[1])
        else $error("far RAI not forwarded");
    a_nofwd_slots: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !full_rate && lock_s && !far_fault_l[2] && !fwd_en[2] && far_ais_l[2] |=> line_out_sel[5:4] == alarm_pkg::OUT_SLOTS1)
        else $error("unforwarded far AIS not limited to slots");
    a_svc_forward: assert property (@(posedge sys_clk) disable iff (!reset_n)
        tick |=> svc_ais == ($past(ais_s) & $past(fwd_en)) && svc_rai == ($past(rai_s) & $past(fwd_en)))
        else $error("line alarms not sent to far end");
    a_svc_fault: assert property (@(posedge sys_clk) disable iff (!reset_n)
        tick |=> svc_fault == $past(los_s))
        else $error("line fault not sent to far end");
    a_slot_rebuild: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !full_rate |=> slot_fill_mask == $past(slot_map))
        else $error("slot mask does not follow map");
    a_fullrate_fwd: assert property (@(posedge sys_clk) disable iff (!reset_n)
        full_rate && lock_s && fwd_en[1] && far_ais_l[1] |=> line_out_sel[3:2] == alarm_pkg::OUT_AIS)
        else $error("full rate far AIS not forwarded");
    a_fullrate_rai: assert property (@(posedge sys_clk) disable iff (!reset_n)
        full_rate && fwd_en[0] && far_rai_l[0] |=> line_tx_rai[0])
        else $error("full rate far RAI not forwarded");
    a_gen_fault: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !full_rate && far_fault_l[2] && gen_en[2] |=> line_out_sel[5:4] == alarm_pkg::OUT_AIS)
        else $error("far fault without generated AIS");
    a_t1_no_mf: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !frac_e1 |=> multiframe_remote_alarm == 4'h0)
        else $error("multiframe alarm outside E1 mode");

    // Main scenarios
    c_unlock: cover property (@(posedge sys_clk) disable iff (!reset_n) $fell(lock_s));
    c_forward: cover property (@(posedge sys_clk) disable iff (!reset_n) tick && |(ais_s & fwd_en));
    c_irq: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(irq));
    c_read_wait: cover property (@(posedge sys_clk) disable iff (!reset_n) avs_read && avs_waitrequest);
    c_zeros: cover property (@(posedge sys_clk) disable iff (!reset_n) line_out_sel[3:2] == alarm_pkg::OUT_ZEROS);

endmodule

// ===== src/svc_tick.sv
// Service channel pacing tick generator, one pulse per period.
// Assumes sys_clk at 250 MHz; the period is a parameter for simulation.
`timescale 1ns/1ns
module svc_tick #(
    parameter int PERIOD = alarm_pkg::SVC_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    output logic      tick
);

    logic [31:0] count;

    // Free running divider
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            count <= 32'h0;
            tick  <= 1'b0;
        end else if (count == 32'(PERIOD - 1)) begin
            count <= 32'h0;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick  <= 1'b0;
        end
    end

endmodule

// ===== tb/line_partner.sv
// Model of the line equipment and of the remote radio behind the handler.
// Assumes the bench requests conditions as one packed vector on sys_clk.
`timescale 1ns/1ns
module line_partner (
    input  wire logic        sys_clk,
    input  wire logic [28:0] want,
    output logic      [3:0]  line_los,
    output logic      [3:0]  line_ais_in,
    output logic      [3:0]  line_rai_in,
    output logic      [3:0]  line_mf_loss,
    output logic             demod_lock,
    output logic      [3:0]  far_ais,
    output logic      [3:0]  far_rai,
    output logic      [3:0]  far_fault
);
    logic [1:0]  pace = 2'h0;
    logic [11:0] far_q = 12'h000;

    // ------------------------------------------------------------
    // Line pins and modem lock follow the request directly
    // ------------------------------------------------------------
    assign {demod_lock, line_mf_loss, line_rai_in, line_ais_in, line_los} = want[16:0];

    // ------------------------------------------------------------
    // Remote flags
    // ------------------------------------------------------------
    // Remote flags move only on a slow pace, never per cycle
    always @(posedge sys_clk) begin
        pace <= pace + 2'h1;
        if (pace == 2'h3) begin
            far_q <= want[28:17];
        end
    end
    assign {far_fault, far_rai, far_ais} = far_q;
endmodule

// ===== tb/tb.sv
// Self-checking bench for the line alarm signal handler.
// Assumes a shortened service period and the line_partner model.
`timescale 1ns/1ns
module tb;
    localparam int          SVC   = 8;
    localparam logic [3:0]  GEN   = 4'h5;
    localparam logic [3:0]  FWD   = 4'h3;
    localparam logic [31:0] SLOTS = 32'h00ff0f0e;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, slot_fill_mask, rd;
    logic        avs_waitrequest, demod_lock, irq;
    logic [3:0]  line_los, line_ais_in, line_rai_in, line_mf_loss, far_ais, far_rai, far_fault;
    logic [3:0]  svc_ais, svc_rai, svc_fault, line_tx_rai, multiframe_remote_alarm;
    logic [7:0]  line_out_sel;
    logic [28:0] want = 29'h0010000;
    int          mismatches = 0;
    int          tests_run = 0;
    logic [7:0]  conds [6] = '{8'h10, 8'h00, 8'h90, 8'h30, 8'h51, 8'h1e};

    // ------------------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------------------
    always #2 sys_clk = ~sys_clk;

    line_alarm_signal_handler #(.SVC_PERIOD(SVC)) u_dut (
        .sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .line_los, .line_ais_in, .line_rai_in, .line_mf_loss, .demod_lock,
        .far_ais, .far_rai, .far_fault, .svc_ais, .svc_rai, .svc_fault, .line_out_sel,
        .line_tx_rai, .multiframe_remote_alarm, .slot_fill_mask, .irq);

    line_partner u_partner (
        .sys_clk, .want, .line_los, .line_ais_in, .line_rai_in, .line_mf_loss, .demod_lock,
        .far_ais, .far_rai, .far_fault);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    // Read data is taken at the edge where waitrequest is seen low
    task automatic read_check(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        check(what, exp, rd);
    endtask

    // Same condition on all lines, then wait out sync and service pacing
    task automatic set_cond(input logic [7:0] c);
        @(posedge sys_clk);
        want <= {{4{c[7]}}, {4{c[6]}}, {4{c[5]}}, c[4], {4{c[3]}}, {4{c[2]}}, {4{c[1]}}, {4{c[0]}}};
        repeat (3 * SVC) @(posedge sys_clk);
        #1;
    endtask

    // Expected transmitter control per line from the requested condition
    task automatic check_lines(input logic [1:0] m, input logic [3:0] g);
        logic [7:0] s;
        logic [3:0] r, mf;
        logic       fr;
        fr = (m == alarm_pkg::full_rate_mode);
        for (int i = 0; i < 4; i++) begin
            if (!want[16]) s[2*i+:2] = (g[i] || fr) ? alarm_pkg::OUT_AIS : alarm_pkg::OUT_SLOTS1;
            else if (fr && FWD[i] && want[17+i]) s[2*i+:2] = alarm_pkg::OUT_AIS;
            else if (want[25+i]) s[2*i+:2] = g[i] ? alarm_pkg::OUT_AIS
                                           : (fr ? alarm_pkg::OUT_ZEROS : alarm_pkg::OUT_SLOTS1);
            else if (!fr && want[17+i]) s[2*i+:2] = FWD[i] ? alarm_pkg::OUT_AIS : alarm_pkg::OUT_SLOTS1;
            else s[2*i+:2] = alarm_pkg::OUT_RECON;
            r[i] = (!fr && g[i] && (want[i] || want[4+i])) || (FWD[i] && want[21+i]);
            mf[i] = (m == alarm_pkg::fractional_e1_mode) && g[i] && want[12+i];
        end
        check("line_out_sel", {24'h0, s}, {24'h0, line_out_sel});
        check("line_tx_rai", {28'h0, r}, {28'h0, line_tx_rai});
        check("mf_alarm", {28'h0, mf}, {28'h0, multiframe_remote_alarm});
        check("svc_ais", {28'h0, want[7:4] & FWD}, {28'h0, svc_ais});
        check("svc_rai", {28'h0, want[11:8] & FWD}, {28'h0, svc_rai});
        check("svc_fault", {28'h0, want[3:0]}, {28'h0, svc_fault});
        check("slot_fill_mask", fr ? 32'h0 : SLOTS, slot_fill_mask);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        read_check("control", alarm_pkg::OFS_CONTROL, {30'h0, alarm_pkg::MODE_RESET});
        read_check("gen_en", alarm_pkg::OFS_GEN_EN, {28'h0, alarm_pkg::EN_RESET});
        read_check("fwd_en", alarm_pkg::OFS_FWD_EN, {28'h0, alarm_pkg::EN_RESET});
        read_check("slot_map", alarm_pkg::OFS_SLOT_MAP, alarm_pkg::SLOT_RESET);
        read_check("irq_mask", alarm_pkg::OFS_IRQ_MASK, 32'h0);
        read_check("unmapped", 8'h1c, 32'h0);
        $display("test reset values done");
        read_check("status", alarm_pkg::OFS_STATUS, 32'h0);
        bus_write(alarm_pkg::OFS_IRQ_MASK, 32'h10);
        set_cond(8'h00);
        check("irq", 32'h1, {31'h0, irq});
        read_check("status", alarm_pkg::OFS_STATUS, 32'h10);
        check("irq", 32'h0, {31'h0, irq});
        bus_write(alarm_pkg::OFS_LIVE, 32'h1ff);
        read_check("live", alarm_pkg::OFS_LIVE, 32'h0);
        set_cond(8'h12);
        check("irq", 32'h0, {31'h0, irq});
        read_check("status", alarm_pkg::OFS_STATUS, 32'h0f);
        $display("test interrupt done");
        bus_write(alarm_pkg::OFS_GEN_EN, {28'h0, GEN});
        bus_write(alarm_pkg::OFS_FWD_EN, {28'h0, FWD});
        bus_write(alarm_pkg::OFS_SLOT_MAP, SLOTS);
        read_check("gen_en", alarm_pkg::OFS_GEN_EN, {28'h0, GEN});
        read_check("fwd_en", alarm_pkg::OFS_FWD_EN, {28'h0, FWD});
        read_check("slot_map", alarm_pkg::OFS_SLOT_MAP, SLOTS);
        $display("test enables done");
        for (int m = 0; m < 4; m++) begin
            bus_write(alarm_pkg::OFS_CONTROL, {30'h0, 2'(m)});
            for (int e = 0; e < 6; e++) begin
                set_cond(conds[e]);
                check_lines(2'(m), GEN);
            end
            $display("test mode %0d done", m);
        end
        bus_write(alarm_pkg::OFS_CONTROL, {30'h0, alarm_pkg::full_rate_mode});
        bus_write(alarm_pkg::OFS_GEN_EN, 32'h0);
        set_cond(8'h90);
        check_lines(alarm_pkg::full_rate_mode, 4'h0);
        $display("test full rate without generation done");
        print_verdict();
    end

    // Watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        print_verdict();
    end
endmodule
